// ===== logic/mii_pkg.sv
// Shared constants and types for the MAC-to-PHY media-independent link
// Operation
// - PHY drives MII transmit clock, 25/2.5 MHz
// - MII transmit clock phase fixed to reference
// - MAC sources RGMII transmit clock, 25/2.5 MHz
// - Transmit clock pin driven low during reset
// - MAC drives transmit enable on rising edge
// - RGMII transmit control: enable rising, error falling
// - MAC transmit data synchronous to rising edge
// - PHY drives receive clock in MII, RGMII
// - Receive valid marks data, independent of carrier
// - RGMII receive control: valid rising, error falling
// - Receive error high on bad symbol
// - PHY corrupts data on receive error
// - Receive data presented on rising edge
// - Station address latched from pulled pins
// - MII carrier sense when either medium busy
// - RMII carrier sense merges carrier and valid
// - RGMII leaves carrier and error pins unused
// - Collision low full duplex, else both busy; the code holds it low in RMII as well
`default_nettype none
package mii_pkg;
  // Nominal link reference rate; every pin rate is derived from it
  localparam int REF_CLK_HZ     = 100_000_000;
  localparam int CLK_HZ_100     = 25_000_000;
  localparam int CLK_HZ_10      = 2_500_000;
  localparam int DIBIT_HZ_100   = 50_000_000;
  localparam int DIBIT_HZ_10    = 5_000_000;
  // Reference cycles per half clock period, and per RMII dibit
  localparam logic [4:0] HALF_100  = 5'(REF_CLK_HZ / (2 * CLK_HZ_100));
  localparam logic [4:0] HALF_10   = 5'(REF_CLK_HZ / (2 * CLK_HZ_10));
  localparam logic [4:0] DIBIT_100 = 5'(REF_CLK_HZ / DIBIT_HZ_100);
  localparam logic [4:0] DIBIT_10  = 5'(REF_CLK_HZ / DIBIT_HZ_10);
  // Address seen when no external strap resistors are fitted
  localparam logic [4:0] STRAP_DEFAULT = 5'h01;

  typedef enum logic [1:0] {
    MODE_MII   = 2'h0,
    MODE_RMII  = 2'h1,
    MODE_RGMII = 2'h3
  } ifMode_t;

  // Reference cycles between steps for the given mode and speed
  function automatic logic [4:0] stepLimit(input logic [1:0] m, input logic s10);
    if (m == MODE_RMII) begin
      return s10 ? DIBIT_10 : DIBIT_100;
    end
    return s10 ? HALF_10 : HALF_100;
  endfunction
endpackage
`default_nettype wire

// ===== logic/mii_link_if.sv
// Pin bundle between MAC and PHY, with two-way pins resolved here
`timescale 1ns/1ps
`default_nettype none
interface mii_link_if;
  logic       txClkPhy;
  logic       txClkPhyOe;
  logic       txClkMac;
  logic       txClk;
  logic       txCtl;
  logic [3:0] txd;
  logic       rxClk;
  logic       rxCtl;
  logic       rxEr;
  logic       crs;
  logic       colDrv;
  logic       colOe;
  logic       col;
  logic [3:0] rxdDrv;
  logic       rxdOe;
  logic [3:0] rxd;
  logic [4:0] strapPull;

  // Undriven pins settle to their strap resistors
  assign txClk = txClkPhyOe ? txClkPhy : txClkMac;
  assign rxd   = rxdOe ? rxdDrv : strapPull[4:1];
  assign col   = colOe ? colDrv : strapPull[0];

  modport phy (
    output txClkPhy, txClkPhyOe, rxClk, rxCtl, rxEr, crs, colDrv, colOe, rxdDrv, rxdOe,
    input  txClk, txCtl, txd, rxd, col
  );
  modport mac (
    output txClkMac, txCtl, txd,
    input  txClk, rxClk, rxCtl, rxEr, crs, col, rxd
  );
endinterface
`default_nettype wire

// ===== logic/mac_mii_port.sv
// MAC end of the media-independent link
`timescale 1ns/1ps
`default_nettype none
module mac_mii_port
  import mii_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [1:0] mode,
  input  wire logic       speed10,
  input  wire logic       linkClk,
  input  wire logic [3:0] userTxData,
  input  wire logic       userTxValid,
  input  wire logic       userTxErr,
  output logic            userTxTake,
  output logic [3:0]      userRxData,
  output logic            userRxStrobe,
  output logic            userRxErr,
  output logic            userCrs,
  output logic            userCol,
  mii_link_if.mac         link
);
  logic       rstM_r;
  logic       ceM_r;
  logic       rstS1_r;
  logic       rstLink_r;
  logic       ceS1_r;
  logic       lce;
  logic [2:0] cfgS1_r;
  logic [2:0] cfgS2_r;
  logic       isMii;
  logic       isRmii;
  logic       isRgmii;
  logic [4:0] lim;
  logic [4:0] stepCnt_r;
  logic       tick;
  logic       phase_r;
  logic       phaseNext;
  logic       riseD_r;
  logic       fallD_r;
  logic [2:0] tcS_r;
  logic [2:0] rcS_r;
  logic [1:0] rctlS_r;
  logic [1:0] rerS_r;
  logic [1:0] crsS_r;
  logic [1:0] colS_r;
  logic [3:0] rdS1_r;
  logic [3:0] rdS2_r;
  logic       txHi_r;
  logic [1:0] txStash_r;
  logic       txErrHold_r;
  logic       rxHoldDv_r;
  logic [3:0] rxHoldD_r;
  logic [4:0] rmCnt_r;
  logic       rmHi_r;
  logic [1:0] rmLo_r;

  // Reset and enable staged in mclk before crossing
  always_ff @(posedge mclk) begin
    rstM_r <= rst;
    ceM_r  <= ce;
  end

  // Two-flop crossing of reset, enable and static settings
  always_ff @(posedge linkClk) begin
    rstS1_r   <= rstM_r;
    rstLink_r <= rstS1_r;
    ceS1_r    <= ceM_r;
    lce       <= ceS1_r;
    cfgS1_r   <= {mode, speed10};
    cfgS2_r   <= cfgS1_r;
  end

  // Decoded settings and step pacing, all from the synchronised copy
  assign isMii   = cfgS2_r[2:1] == MODE_MII;
  assign isRmii  = cfgS2_r[2:1] == MODE_RMII;
  assign isRgmii = cfgS2_r[2:1] == MODE_RGMII;
  assign lim     = stepLimit(cfgS2_r[2:1], cfgS2_r[0]);
  assign tick    = stepCnt_r == 5'(lim - 5'h1);
  assign phaseNext = tick ? ~phase_r : phase_r;

  // Divider for the RGMII transmit clock and RMII step pacing
  always_ff @(posedge linkClk) begin
    if (rstLink_r) begin
      stepCnt_r <= 5'h00;
      phase_r   <= 1'b0;
      riseD_r   <= 1'b0;
      fallD_r   <= 1'b0;
      link.txClkMac <= 1'b0;
    end else if (lce) begin
      stepCnt_r <= tick ? 5'h00 : 5'(stepCnt_r + 5'h1);
      phase_r   <= phaseNext;
      riseD_r   <= tick & ~phase_r;
      fallD_r   <= tick & phase_r;
      link.txClkMac <= isRgmii & phaseNext;
    end
  end

  // Pins from the PHY side pass two flops; edges read from stages two and three
  always_ff @(posedge linkClk) begin
    if (lce) begin
      tcS_r   <= {tcS_r[1:0], link.txClk};
      rcS_r   <= {rcS_r[1:0], link.rxClk};
      rctlS_r <= {rctlS_r[0], link.rxCtl};
      rerS_r  <= {rerS_r[0], link.rxEr};
      crsS_r  <= {crsS_r[0], link.crs};
      colS_r  <= {colS_r[0], link.col};
      rdS1_r  <= link.rxd;
      rdS2_r  <= rdS1_r;
    end
  end

  // Transmit: MII data changes three cycles after the clock rises, RGMII one cycle after each edge, so the PHY never sees a race
  always_ff @(posedge linkClk) begin
    if (rstLink_r) begin
      link.txCtl  <= 1'b0;
      link.txd    <= 4'h0;
      userTxTake  <= 1'b0;
      txHi_r      <= 1'b0;
      txStash_r   <= 2'h0;
      txErrHold_r <= 1'b0;
    end else if (lce) begin
      userTxTake <= 1'b0;
      if (isMii && tcS_r[1] && !tcS_r[2]) begin
        link.txCtl <= userTxValid;
        link.txd   <= userTxData;
        userTxTake <= userTxValid;
      end else if (isRgmii && fallD_r) begin
        link.txCtl  <= userTxValid;
        link.txd    <= userTxData;
        txErrHold_r <= userTxValid & userTxErr;
        userTxTake  <= userTxValid;
      end else if (isRgmii && riseD_r) begin
        link.txCtl <= txErrHold_r;
      end else if (isRmii && tick) begin
        if (txHi_r) begin
          link.txd <= {2'h0, txStash_r};
          txHi_r   <= 1'b0;
        end else begin
          link.txCtl <= userTxValid;
          link.txd   <= {2'h0, userTxData[1:0]};
          txStash_r  <= userTxData[3:2];
          txHi_r     <= userTxValid;
          userTxTake <= userTxValid;
        end
      end
    end
  end

  // Receive: nibbles on rising edge, RGMII error on falling, RMII dibits low first
  always_ff @(posedge linkClk) begin
    if (rstLink_r) begin
      userRxData   <= 4'h0;
      userRxStrobe <= 1'b0;
      userRxErr    <= 1'b0;
      userCrs      <= 1'b0;
      userCol      <= 1'b0;
      rxHoldDv_r   <= 1'b0;
      rxHoldD_r    <= 4'h0;
      rmCnt_r      <= 5'h00;
      rmHi_r       <= 1'b0;
      rmLo_r       <= 2'h0;
    end else if (lce) begin
      userRxStrobe <= 1'b0;
      userCrs      <= ~isRgmii & crsS_r[1];
      userCol      <= colS_r[1];
      if (isMii && rcS_r[1] && !rcS_r[2] && rctlS_r[1]) begin
        userRxData   <= rdS2_r;
        userRxErr    <= rerS_r[1];
        userRxStrobe <= 1'b1;
      end else if (isRgmii && rcS_r[1] && !rcS_r[2]) begin
        rxHoldDv_r <= rctlS_r[1];
        rxHoldD_r  <= rdS2_r;
      end else if (isRgmii && !rcS_r[1] && rcS_r[2] && rxHoldDv_r) begin
        userRxData   <= rxHoldD_r;
        userRxErr    <= rctlS_r[1];
        userRxStrobe <= 1'b1;
      end
      // RMII sampling starts at the valid edge and hits mid-dibit
      if (!isRmii || !rctlS_r[1]) begin
        rmCnt_r <= 5'h00;
        rmHi_r  <= 1'b0;
      end else begin
        rmCnt_r <= (rmCnt_r == 5'(lim - 5'h1)) ? 5'h00 : 5'(rmCnt_r + 5'h1);
        if (rmCnt_r == (lim >> 1)) begin
          rmHi_r <= ~rmHi_r;
          rmLo_r <= rdS2_r[1:0];
          if (rmHi_r) begin
            userRxData   <= {rdS2_r[1:0], rmLo_r};
            userRxErr    <= rerS_r[1];
            userRxStrobe <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/phy_mac_port.sv
// PHY end of the media-independent link, facing the MAC
`timescale 1ns/1ps
`default_nettype none
module phy_mac_port
  import mii_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic [1:0] mode,
  input  wire logic       speed10,
  input  wire logic       fullDuplex,
  input  wire logic       linkClk,
  input  wire logic [3:0] lineRxData,
  input  wire logic       lineRxValid,
  input  wire logic       lineRxErr,
  input  wire logic       lineRxCarrier,
  output logic            lineRxTake,
  output logic [3:0]      lineTxData,
  output logic            lineTxEn,
  output logic            lineTxErr,
  output logic            lineTxStrobe,
  output logic [4:0]      stationAddress,
  mii_link_if.phy         link
);
  logic       rstM_r;
  logic       ceM_r;
  logic [4:0] strapS1_r;
  logic [4:0] strapS2_r;
  logic       rstS1_r;
  logic       rstLink_r;
  logic       ceS1_r;
  logic       lce;
  logic [3:0] cfgS1_r;
  logic [3:0] cfgS2_r;
  logic       isMii;
  logic       isRmii;
  logic       isRgmii;
  logic       isFull;
  logic [4:0] lim;
  logic [4:0] stepCnt_r;
  logic       tick;
  logic       phase_r;
  logic       phaseNext;
  logic       riseEdge;
  logic       riseD_r;
  logic       fallD_r;
  logic       rxStep;
  logic [3:0] rxNib;
  logic       rxHi_r;
  logic [1:0] rxStash_r;
  logic       rxErSeen_r;
  logic [2:0] tcS_r;
  logic [1:0] tctlS_r;
  logic [3:0] tdS1_r;
  logic [3:0] tdS2_r;
  logic       tcRise;
  logic       tcFall;
  logic       txHi_r;
  logic [1:0] txLo_r;
  logic       enHold_r;
  logic [3:0] dHold_r;
  logic       txActive_r;

  // Reset and enable staged in mclk before crossing
  always_ff @(posedge mclk) begin
    rstM_r <= rst;
    ceM_r  <= ce;
  end

  // Strap pins cross into mclk through two flops
  always_ff @(posedge mclk) begin
    if (ce) begin
      strapS1_r <= {link.rxd, link.col};
      strapS2_r <= strapS1_r;
    end
  end

  // Address follows the straps while reset holds, last value kept at release
  always_ff @(posedge mclk) begin
    if (ce && rst) begin
      stationAddress <= strapS2_r;
    end
  end

  // Two-flop crossing of reset, enable and static settings
  always_ff @(posedge linkClk) begin
    rstS1_r   <= rstM_r;
    rstLink_r <= rstS1_r;
    ceS1_r    <= ceM_r;
    lce       <= ceS1_r;
    cfgS1_r   <= {mode, speed10, fullDuplex};
    cfgS2_r   <= cfgS1_r;
  end

  // Static mode and speed select every pin behaviour below
  assign isMii   = cfgS2_r[3:2] == MODE_MII;
  assign isRmii  = cfgS2_r[3:2] == MODE_RMII;
  assign isRgmii = cfgS2_r[3:2] == MODE_RGMII;
  assign isFull  = cfgS2_r[0];
  assign lim     = stepLimit(cfgS2_r[3:2], cfgS2_r[1]);
  assign tick    = stepCnt_r == 5'(lim - 5'h1);
  assign phaseNext = tick ? ~phase_r : phase_r;
  assign riseEdge  = tick & ~phase_r;

  // Divider from the reference; counting from its edges fixes the phase
  always_ff @(posedge linkClk) begin
    if (rstLink_r) begin
      stepCnt_r <= 5'h00;
      phase_r   <= 1'b0;
      riseD_r   <= 1'b0;
      fallD_r   <= 1'b0;
    end else if (lce) begin
      stepCnt_r <= tick ? 5'h00 : 5'(stepCnt_r + 5'h1);
      phase_r   <= phaseNext;
      riseD_r   <= riseEdge;
      fallD_r   <= tick & phase_r;
    end
  end

  // Clock pins; transmit clock pin is a low output until reset ends
  always_ff @(posedge linkClk) begin
    if (rstLink_r) begin
      link.txClkPhy   <= 1'b0;
      link.txClkPhyOe <= 1'b1;
      link.rxClk      <= 1'b0;
    end else if (lce) begin
      link.txClkPhyOe <= isMii;
      link.txClkPhy   <= isMii & phaseNext;
      link.rxClk      <= ~isRmii & phaseNext;
    end
  end

  // Bad symbols reach the MAC as corrupted data even if it ignores the error pin
  assign rxNib  = lineRxErr ? ~lineRxData : lineRxData;
  assign rxStep = isRmii ? tick : fallD_r;

  // Receive: change one cycle after the falling edge, so stable at the rising one; RGMII error on rxCtl one cycle after the rising edge
  always_ff @(posedge linkClk) begin
    if (rstLink_r) begin
      link.rxdDrv <= 4'h0;
      link.rxCtl  <= 1'b0;
      link.rxEr   <= 1'b0;
      lineRxTake  <= 1'b0;
      rxHi_r      <= 1'b0;
      rxStash_r   <= 2'h0;
      rxErSeen_r  <= 1'b0;
    end else if (lce) begin
      lineRxTake <= 1'b0;
      if (rxStep && isRmii && rxHi_r) begin
        link.rxdDrv <= {2'h0, rxStash_r};
        rxHi_r      <= 1'b0;
      end else if (rxStep) begin
        lineRxTake <= lineRxValid;
        link.rxCtl <= lineRxValid;
        link.rxEr  <= ~isRgmii & lineRxValid & lineRxErr;
        rxErSeen_r <= lineRxValid & lineRxErr;
        if (isRmii) begin
          link.rxdDrv <= {2'h0, rxNib[1:0]};
          rxStash_r   <= rxNib[3:2];
          rxHi_r      <= lineRxValid;
        end else begin
          link.rxdDrv <= rxNib;
        end
      end else if (isRgmii && riseD_r) begin
        link.rxCtl <= rxErSeen_r;
      end
    end
  end

  // RGMII transmit clock belongs to the MAC: pins cross through two flops
  always_ff @(posedge linkClk) begin
    if (lce) begin
      tcS_r   <= {tcS_r[1:0], link.txClk};
      tctlS_r <= {tctlS_r[0], link.txCtl};
      tdS1_r  <= link.txd;
      tdS2_r  <= tdS1_r;
    end
  end

  // Edges of the MAC clock, seen only past both sync stages
  assign tcRise = tcS_r[1] & ~tcS_r[2];
  assign tcFall = ~tcS_r[1] & tcS_r[2];

  // Transmit capture toward the line; MII and RMII pins share our clock
  always_ff @(posedge linkClk) begin
    if (rstLink_r) begin
      lineTxData   <= 4'h0;
      lineTxEn     <= 1'b0;
      lineTxErr    <= 1'b0;
      lineTxStrobe <= 1'b0;
      txHi_r       <= 1'b0;
      txLo_r       <= 2'h0;
      enHold_r     <= 1'b0;
      dHold_r      <= 4'h0;
      txActive_r   <= 1'b0;
    end else if (lce) begin
      lineTxStrobe <= 1'b0;
      if (isMii && riseEdge) begin
        lineTxEn     <= link.txCtl;
        lineTxData   <= link.txd;
        lineTxErr    <= 1'b0;
        lineTxStrobe <= link.txCtl;
        txActive_r   <= link.txCtl;
      end else if (isRmii && tick) begin
        if (txHi_r) begin
          lineTxData   <= {link.txd[1:0], txLo_r};
          lineTxEn     <= 1'b1;
          lineTxErr    <= 1'b0;
          lineTxStrobe <= 1'b1;
          txHi_r       <= 1'b0;
        end else begin
          txActive_r <= link.txCtl;
          txLo_r     <= link.txd[1:0];
          txHi_r     <= link.txCtl;
          if (!link.txCtl) begin
            lineTxEn <= 1'b0;
          end
        end
      end else if (isRgmii && tcRise) begin
        enHold_r <= tctlS_r[1];
        dHold_r  <= tdS2_r;
      end else if (isRgmii && tcFall) begin
        lineTxEn     <= enHold_r;
        lineTxData   <= dHold_r;
        lineTxErr    <= tctlS_r[1];
        lineTxStrobe <= enHold_r;
        txActive_r   <= enHold_r;
      end
    end
  end

  // Carrier sense and collision; drivers off in reset so straps can be read
  always_ff @(posedge linkClk) begin
    if (rstLink_r) begin
      link.crs    <= 1'b0;
      link.colDrv <= 1'b0;
      link.colOe  <= 1'b0;
      link.rxdOe  <= 1'b0;
    end else if (lce) begin
      link.colOe <= 1'b1;
      link.rxdOe <= 1'b1;
      if (isMii) begin
        link.crs <= lineRxCarrier | txActive_r;
      end else if (isRmii) begin
        link.crs <= lineRxCarrier | link.rxCtl;
      end else begin
        link.crs <= 1'b0;
      end
      // Unused in RMII, so it reads low there
      link.colDrv <= ~isFull & ~isRmii & lineRxCarrier & txActive_r;
    end
  end
endmodule
`default_nettype wire

// ===== verification/mii_link_properties.sv
// Concurrent checks on the MAC/PHY link pins, judged in the link clock
`timescale 1ns/1ps
`default_nettype none
module mii_link_properties
  import mii_pkg::*;
(
  input wire logic       linkClk,
  input wire logic       rst,
  input wire logic [1:0] mode,
  input wire logic       speed10,
  input wire logic       fullDuplex,
  input wire logic       txClkPhy,
  input wire logic       txClkPhyOe,
  input wire logic       txCtl,
  input wire logic       rxClk,
  input wire logic       rxCtl,
  input wire logic       rxEr,
  input wire logic       crs,
  input wire logic       colDrv,
  input wire logic       colOe,
  input wire logic [3:0] rxdDrv
);
  logic [2:0] upCnt_r;
  logic       live;

  // Link reset trails rst by a few edges, so wait before judging pins
  always_ff @(posedge linkClk) begin
    if (rst) begin
      upCnt_r <= 3'h0;
    end else if (upCnt_r != 3'h7) begin
      upCnt_r <= upCnt_r + 3'h1;
    end
  end
  assign live = (upCnt_r == 3'h7);

  default clocking @(posedge linkClk); endclocking
  default disable iff (rst);

  // Reset itself is the cause here, so this one is never disabled
  AST_TXCLK_RST: assert property (disable iff (1'b0) rst [*6] |-> txClkPhyOe && !txClkPhy)
    else $error("transmit clock pin not a low output in reset");
  AST_TXCLK_OUT_MII: assert property (live && mode == MODE_MII |-> txClkPhyOe)
    else $error("transmit clock not driven by PHY in MII");
  AST_TXCLK_IN_RGMII: assert property (live && mode == MODE_RGMII |-> !txClkPhyOe)
    else $error("transmit clock pin still an output after reset");
  AST_TXCLK_HALF: assert property (live && mode == MODE_MII && !speed10 && $rose(txClkPhy)
    |-> ##1 txClkPhy ##1 !txClkPhy)
    else $error("transmit clock high phase wrong");
  AST_RXCLK_HALF: assert property (live && mode != MODE_RMII && !speed10 && $fell(rxClk)
    |-> ##1 !rxClk ##1 rxClk)
    else $error("receive clock low phase wrong");
  AST_RXD_STABLE: assert property (live && mode != MODE_RMII && $rose(rxClk)
    |-> $stable(rxdDrv) && $stable(rxCtl))
    else $error("receive data moved at the rising receive clock");
  AST_RMII_NO_CLK: assert property (live && mode == MODE_RMII |-> !txClkPhyOe && !rxClk)
    else $error("clock pins active in RMII");
  AST_RMII_CRS: assert property (live && mode == MODE_RMII && rxCtl |-> ##[0:1] crs)
    else $error("combined carrier missing while receive valid");
  AST_RGMII_UNUSED: assert property (live && mode == MODE_RGMII |-> !crs && !rxEr)
    else $error("carrier or error pin active in RGMII");
  AST_COL_FULL: assert property (live && fullDuplex && colOe |-> !colDrv)
    else $error("collision driven high in full duplex");

  // Main traffic seen in each mode, plus a driven collision
  cover property (live && mode == MODE_MII && rxCtl);
  cover property (live && mode == MODE_RMII && crs);
  cover property (live && mode == MODE_RGMII && txCtl);
  cover property (live && colOe && colDrv);
endmodule
`default_nettype wire

// ===== verification/phy_mac_side_mii_rmii_rgmii_tb.sv
// Bench joining MAC and PHY ends back to back in every mode
`timescale 1ns/1ps
`default_nettype none
module phy_mac_side_mii_rmii_rgmii_tb import mii_pkg::*;;
  `define CHK(nm, e, g) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      n_mismatch++; \
      $display("BAD %s exp=%0h got=%0h", nm, e, g); \
    end \
  end
  logic       mclk = 1'b0;
  logic       linkClk = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] mode = MODE_MII;
  logic       speed10 = 1'b0;
  logic       fullDuplex = 1'b0;
  logic [3:0] userTxData = 4'h0;
  logic       userTxValid = 1'b0;
  logic       userTxErr = 1'b0;
  logic [3:0] lineRxData = 4'h0;
  logic       lineRxValid = 1'b0;
  logic       lineRxErr = 1'b0;
  logic       lineRxCarrier = 1'b0;
  logic       lineRxTake, lineTxEn, lineTxErr, lineTxStrobe;
  logic       userTxTake, userRxStrobe, userRxErr, userCrs, userCol;
  logic [3:0] lineTxData, userRxData;
  logic [4:0] stationAddress;
  logic [4:0] txGot[$], rxGot[$];
  logic [7:0] txCyc, rxCyc, txPer, rxPer;
  logic       txPrev, rxPrev, sawCol, sawCrs, sawUCol, sawUCrs;
  int         txIdx, rxIdx, txCnt, rxCnt, tErrAt, rErrAt, n_mismatch, comparisons;

  always #10 mclk = ~mclk;
  // Link clock offset so its edges never meet the system clock's
  initial begin
    #7;
    forever #24 linkClk = ~linkClk;
  end

  mii_link_if link ();
  phy_mac_port u_phy_mac_port (
    .mclk(mclk), .rst(rst), .ce(1'b1), .mode(mode), .speed10(speed10),
    .fullDuplex(fullDuplex), .linkClk(linkClk), .lineRxData(lineRxData),
    .lineRxValid(lineRxValid), .lineRxErr(lineRxErr), .lineRxCarrier(lineRxCarrier),
    .lineRxTake(lineRxTake), .lineTxData(lineTxData), .lineTxEn(lineTxEn),
    .lineTxErr(lineTxErr), .lineTxStrobe(lineTxStrobe),
    .stationAddress(stationAddress), .link(link));
  mac_mii_port u_mac_mii_port (
    .mclk(mclk), .rst(rst), .ce(1'b1), .mode(mode), .speed10(speed10),
    .linkClk(linkClk), .userTxData(userTxData), .userTxValid(userTxValid),
    .userTxErr(userTxErr), .userTxTake(userTxTake), .userRxData(userRxData),
    .userRxStrobe(userRxStrobe), .userRxErr(userRxErr), .userCrs(userCrs), .userCol(userCol),
    .link(link));
  mii_link_properties u_mii_link_properties (
    .linkClk(linkClk), .rst(rst), .mode(mode), .speed10(speed10),
    .fullDuplex(fullDuplex), .txClkPhy(link.txClkPhy), .txClkPhyOe(link.txClkPhyOe),
    .txCtl(link.txCtl), .rxClk(link.rxClk), .rxCtl(link.rxCtl), .rxEr(link.rxEr),
    .crs(link.crs), .colDrv(link.colDrv), .colOe(link.colOe), .rxdDrv(link.rxdDrv));

  // Sources and monitors on the falling edge, clear of register updates
  always @(negedge linkClk) begin
    if (userTxTake === 1'b1) txIdx++;
    if (lineRxTake === 1'b1) rxIdx++;
    userTxValid = txIdx < txCnt;
    userTxData = 4'(txIdx * 5 + 3);
    userTxErr = txIdx == tErrAt;
    lineRxValid = rxIdx < rxCnt;
    lineRxCarrier = rxIdx < rxCnt;
    lineRxData = 4'(rxIdx * 7 + 9);
    lineRxErr = rxIdx == rErrAt;
    if (lineTxStrobe === 1'b1 && lineTxEn === 1'b1) txGot.push_back({lineTxErr, lineTxData});
    if (userRxStrobe === 1'b1) rxGot.push_back({userRxErr, userRxData});
    if (link.colOe === 1'b1 && link.colDrv === 1'b1) sawCol = 1'b1;
    if (link.crs === 1'b1) sawCrs = 1'b1;
    // MAC-side status as the user logic sees it
    if (userCol === 1'b1) sawUCol = 1'b1;
    if (userCrs === 1'b1) sawUCrs = 1'b1;
    if (link.txClk === 1'b1 && txPrev === 1'b0) begin
      txPer = txCyc;
      txCyc = 8'h00;
    end
    if (link.rxClk === 1'b1 && rxPrev === 1'b0) begin
      rxPer = rxCyc;
      rxCyc = 8'h00;
    end
    txCyc++;
    rxCyc++;
    txPrev = link.txClk;
    rxPrev = link.rxClk;
  end

  task automatic doReset(input logic [1:0] m, input logic s10, input logic fd,
                         input logic [4:0] strap);
    @(negedge mclk);
    rst = 1'b1;
    txCnt = 0;
    rxCnt = 0;
    mode = m;
    speed10 = s10;
    fullDuplex = fd;
    link.strapPull = strap;
    repeat (20) @(negedge mclk);
    `CHK("txClkInReset", 2'b10, {link.txClkPhyOe, link.txClk})
    `CHK("strapPins", strap, {link.rxd, link.col})
    rst = 1'b0;
    repeat (12) @(negedge linkClk);
    `CHK("stationAddress", strap, stationAddress)
  endtask

  // Both directions at once; errors injected at the given nibble
  task automatic frame(input int n, input int tErr, input int rErr, input logic expCol);
    int w;
    w = 0;
    @(posedge linkClk);
    txGot.delete();
    rxGot.delete();
    sawCol = 1'b0;
    sawCrs = 1'b0;
    sawUCol = 1'b0;
    sawUCrs = 1'b0;
    tErrAt = tErr;
    rErrAt = rErr;
    txIdx = 0;
    rxIdx = 0;
    txCnt = n;
    rxCnt = n;
    while ((txGot.size() < n || rxGot.size() < n) && w < 4000) begin
      @(posedge linkClk);
      w++;
    end
    repeat (60) @(posedge linkClk);
    `CHK("txCount", n, txGot.size())
    `CHK("rxCount", n, rxGot.size())
    for (int i = 0; i < n; i++) begin
      `CHK("txNibble", {mode == MODE_RGMII && i == tErr, 4'(i * 5 + 3)}, txGot[i])
      `CHK("rxNibble", {i == rErr, 4'(i * 7 + 9) ^ {4{i == rErr}}}, rxGot[i])
    end
    `CHK("collision", expCol, sawCol)
    `CHK("carrier", mode != MODE_RGMII, sawCrs)
    `CHK("userCollision", expCol, sawUCol)
    `CHK("userCarrier", mode != MODE_RGMII, sawUCrs)
    `CHK("carrierIdle", 1'b0, link.crs)
    if (mode != MODE_RMII) begin
      `CHK("txPeriod", speed10 ? 8'(2 * HALF_10) : 8'(2 * HALF_100), txPer)
      `CHK("rxPeriod", speed10 ? 8'(2 * HALF_10) : 8'(2 * HALF_100), rxPer)
    end
  endtask

  task automatic scenMii100(); // Half duplex; MAC error flag has no pin here
    doReset(MODE_MII, 1'b0, 1'b0, 5'h01);
    frame(6, 1, 2, 1'b1);
  endtask
  task automatic scenMii10();
    doReset(MODE_MII, 1'b1, 1'b1, 5'h16);
    frame(3, -1, 0, 1'b0);
  endtask
  task automatic scenRmii(); // Error on the last nibble
    doReset(MODE_RMII, 1'b0, 1'b0, 5'h0b);
    `CHK("rmiiTxClkOe", 1'b0, link.txClkPhyOe)
    frame(6, -1, 5, 1'b0);
  endtask
  task automatic scenRgmii();
    doReset(MODE_RGMII, 1'b0, 1'b0, 5'h01);
    `CHK("rgmiiTxClkOe", 1'b0, link.txClkPhyOe)
    frame(5, 3, 1, 1'b1);
  endtask

  task automatic summarize();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    link.strapPull = 5'h01;
    repeat (8) @(negedge mclk);
    scenMii100();
    scenMii10();
    scenRmii();
    scenRgmii();
    summarize();
  end
  // Whole run needs well under this span
  initial begin
    #200us;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
